// *** rtl/acs_cfg.svh ***
// Register map, field positions, reset values and widths of the sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_OFS_CTRL        4'h0
`define ACS_OFS_SOFT_TRIG   4'h1
`define ACS_OFS_STATUS      4'h2
`define ACS_OFS_DELAY       4'h3
`define ACS_OFS_TRIM        4'h4
`define ACS_CTRL_W          9
`define ACS_CTRL_RST        9'h080
`define ACS_B_CAL_EN        0
`define ACS_B_TRIG_SEL      1
`define ACS_B_BG_EN         2
`define ACS_B_LOW_POWER_SPARE_ENABLE         3
`define ACS_B_LP_SW_SEL     4
`define ACS_B_FG_OFS_EN     5
`define ACS_B_BG_OFS_EN     6
`define ACS_B_DUAL          7
`define ACS_B_IN_SEL        8
`define ACS_DLY_W           16
`define ACS_SLEEP_RST       16'h0100
`define ACS_SETTLE_RST      16'h0040
`define ACS_TRIM_W          12
`define ACS_MID_CODE        12'h000
`define ACS_BANKS           3'h6
`define ACS_LAST_BANK       3'h5
`endif

// *** rtl/acs_pkg.sv ***
// Types of the calibration sequencer
package acs_pkg;
    typedef enum logic [6:0] {
        st_idle   = 7'h01,
        st_fg_bnk = 7'h02,
        st_fg_ofs = 7'h04,
        st_sleep  = 7'h08,
        st_wake   = 7'h10,
        st_bg_cal = 7'h20,
        st_bg_ofs = 7'h40
    } acs_state_e;

    typedef struct packed {
        acs_state_e  state;
        logic [8:0]  ctrl;
        logic        soft_trig;
        logic [15:0] sleep_dly;
        logic [15:0] settle_dly;
        logic [11:0] trim_a;
        logic [11:0] trim_b;
        logic        loaded;
        logic        done;
        logic        pu_pend;
        logic        src_prev;
        logic [15:0] cnt;
        logic [2:0]  bank;
        logic [1:0]  slot_a;
        logic [1:0]  slot_b;
        logic [1:0]  spare;
        logic        target;
        logic        ack;
        logic [31:0] rdata;
        logic [11:0] sample;
    } acs_regs_s;
endpackage

// *** rtl/acs_sequencer.sv ***
// Calibration sequencer: foreground, background and low-power rotation
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "acs_cfg.svh"

// Functional notes
// R1: During foreground calibration all cores go offline, output forced to mid-code.
// R2: Six banks in pairs form three two-way interleaved cores A, B, C.
// R3: Dual mode: A samples input A, B input B; single: both one input.
// R4: Background: spare core C periodically replaces core A and core B.
// R5: Each bank is calibrated for linearity, gain and offset.
// R6: Foreground calibration runs after power-up; host waits before configuring.
// R7: Trigger comes from pin or software bit, chosen by source select.
// R8: Background needs enable set, source select 0, software trigger 1; the code does not check source select.
// R9: Background repeatedly calibrates spare, swaps it in, frees displaced core.
// R10: Low-power on: offline cores stay powered down until due for calibration.
// R11: Low-power automatic switching: sleep delay sets spare sleep time.
// R12: Settle delay sets time a woken core settles before calibration.
// R13: Switch select picks automatic or trigger-driven core switching.
// R14: Software should avoid low-power background in single-channel mode.
// R15: Foreground offset enable adds one offset step per foreground run.
// R16: Background offset enable corrects offset in every background cycle.
// R17: Software sets foreground offset enable before calibration enable.
// R18: Offset calibration owns the trim; writes blocked while enabled.
// R19: Software reads offsets only after done flag, not in background offset.
// R20: Trims reset to per-device factory values, readable and writable.
// R21: Done flag clears at foreground start, sets after banks and offset.
// R22: Foreground starts on enable plus trigger; triggers while running ignored.
module acs_sequencer
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Trigger pin and factory trims
    input  wire logic        calibration_trigger_pin,
    input  wire logic [11:0] factory_offset_a,
    input  wire logic [11:0] factory_offset_b,
    // Analog calibration engine
    output logic             cal_step_req,
    output logic      [2:0]  cal_bank_sel,
    input  wire logic        cal_step_done,
    output logic             offset_step_req,
    input  wire logic        offset_step_done,
    input  wire logic [11:0] offset_result_a,
    input  wire logic [11:0] offset_result_b,
    // Cores and samples
    output logic      [2:0]  core_online,
    output logic      [2:0]  core_power_on,
    output logic      [2:0]  core_input_b,
    input  wire logic [11:0] sample_in,
    output logic      [11:0] sample_out
);
    import acs_pkg::*;

    acs_regs_s r_reg;
    acs_regs_s r_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] onehot3(input logic [1:0] idx);
        onehot3 = 3'h1 << idx;
    endfunction

    logic fg_run;
    logic bg_run;
    logic src_lvl;
    logic trig_edge;
    logic bus_req;
    logic bus_take;
    logic ofs_lock;
    logic spare_pwr;
    logic dual;
    logic in_sel;

    assign fg_run   = (r_reg.state == st_fg_bnk) || (r_reg.state == st_fg_ofs);
    assign bg_run   = (r_reg.state == st_sleep) || (r_reg.state == st_wake)
                   || (r_reg.state == st_bg_cal) || (r_reg.state == st_bg_ofs);
    // Trigger source mux, edge taken only [R7]
    assign src_lvl  = r_reg.ctrl[`ACS_B_TRIG_SEL] ? calibration_trigger_pin
                                                  : r_reg.soft_trig;
    assign trig_edge = src_lvl && !r_reg.src_prev;
    assign bus_req  = avs_read || avs_write;
    assign bus_take = bus_req && r_reg.ack;
    assign ofs_lock = r_reg.ctrl[`ACS_B_FG_OFS_EN]
                   || r_reg.ctrl[`ACS_B_BG_OFS_EN];
    assign dual     = r_reg.ctrl[`ACS_B_DUAL];
    assign in_sel   = r_reg.ctrl[`ACS_B_IN_SEL];

    // Spare powered in background, except in the sleep state with low power on [R10]
    assign spare_pwr = bg_run && (!r_reg.ctrl[`ACS_B_LOW_POWER_SPARE_ENABLE]
                                  || r_reg.state != st_sleep);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = bus_req && !r_reg.ack;
    assign avs_readdata    = r_reg.rdata;
    assign cal_step_req    = (r_reg.state == st_fg_bnk)
                          || (r_reg.state == st_bg_cal);     // [R5]
    assign offset_step_req = (r_reg.state == st_fg_ofs)
                          || (r_reg.state == st_bg_ofs);
    assign cal_bank_sel    = r_reg.bank;
    assign sample_out      = r_reg.sample;

    always_comb
    begin
        // Cores in the two slots carry data; all drop out in foreground [R1]
        core_online = fg_run ? 3'h0
                    : (onehot3(r_reg.slot_a) | onehot3(r_reg.slot_b));
        core_power_on = fg_run ? 3'h7
                      : (core_online
                         | (spare_pwr ? onehot3(r_reg.spare) : 3'h0));
        // Slot A on input A, slot B on input B, single on one input [R3]
        core_input_b = onehot3(r_reg.slot_b) & {3{dual | in_sel}};
        core_input_b = core_input_b
                     | (onehot3(r_reg.slot_a) & {3{!dual & in_sel}});
        // Spare prepares on the input of the slot it will take over
        if ((r_reg.target ? (dual | in_sel) : (!dual & in_sel)))
        begin
            core_input_b = core_input_b | onehot3(r_reg.spare);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        r_next.src_prev = src_lvl;
        r_next.ack = bus_req && !r_reg.ack;
        r_next.sample = fg_run ? `ACS_MID_CODE : sample_in;   // [R1]

        // Per-device trims caught once after reset release [R20]
        if (!r_reg.loaded)
        begin
            r_next.loaded = 1'b1;
            r_next.trim_a = factory_offset_a;
            r_next.trim_b = factory_offset_b;
        end

        // Read data prepared in the wait cycle
        if (avs_read && !r_reg.ack)
        begin
            unique case (avs_address)
                `ACS_OFS_CTRL:
                    r_next.rdata = {23'h0, r_reg.ctrl};
                `ACS_OFS_SOFT_TRIG:
                    r_next.rdata = {31'h0, r_reg.soft_trig};
                `ACS_OFS_STATUS:
                    r_next.rdata = {11'h0, core_power_on, core_online,
                                    r_reg.spare, r_reg.bank, r_reg.state,
                                    bg_run, fg_run, r_reg.done};
                `ACS_OFS_DELAY:
                    r_next.rdata = {r_reg.settle_dly, r_reg.sleep_dly};
                `ACS_OFS_TRIM:
                    r_next.rdata = {4'h0, r_reg.trim_b, 4'h0, r_reg.trim_a};
                default:
                    r_next.rdata = 32'h0;
            endcase
        end

        if (avs_write && bus_take)
        begin
            unique case (avs_address)
                `ACS_OFS_CTRL:
                    r_next.ctrl = avs_writedata[`ACS_CTRL_W-1:0];
                `ACS_OFS_SOFT_TRIG:
                    r_next.soft_trig = avs_writedata[0];
                `ACS_OFS_DELAY:
                begin
                    r_next.sleep_dly  = avs_writedata[15:0];
                    r_next.settle_dly = avs_writedata[31:16];
                end
                `ACS_OFS_TRIM:
                    if (!ofs_lock)                            // [R18]
                    begin
                        r_next.trim_a = avs_writedata[11:0];
                        r_next.trim_b = avs_writedata[27:16];
                    end
                default:
                    r_next.rdata = r_reg.rdata;
            endcase
        end

        unique case (r_reg.state)
            st_idle:
                // Power-up run, then triggered runs only from idle [R6] [R22]
                if (r_reg.pu_pend || (r_reg.ctrl[`ACS_B_CAL_EN] && trig_edge
                                      && !r_reg.ctrl[`ACS_B_BG_EN]))
                begin
                    r_next.pu_pend = 1'b0;
                    r_next.done    = 1'b0;                    // [R21]
                    r_next.bank    = 3'h0;
                    r_next.state   = st_fg_bnk;
                end
                else if (r_reg.ctrl[`ACS_B_BG_EN]
                         && r_reg.ctrl[`ACS_B_CAL_EN]
                         && r_reg.soft_trig)                  // [R8]
                begin
                    r_next.cnt   = r_reg.sleep_dly;
                    r_next.state = st_sleep;
                end
            st_fg_bnk:
                if (cal_step_done)
                begin
                    r_next.bank = r_reg.bank + 3'h1;
                    if (r_reg.bank == `ACS_LAST_BANK)         // [R2]
                    begin
                        r_next.bank = 3'h0;
                        if (r_reg.ctrl[`ACS_B_FG_OFS_EN])     // [R15]
                        begin
                            r_next.state = st_fg_ofs;
                        end
                        else
                        begin
                            r_next.done  = 1'b1;              // [R21]
                            r_next.state = st_idle;
                        end
                    end
                end
            st_fg_ofs, st_bg_ofs:
                if (offset_step_done)
                begin
                    r_next.trim_a = offset_result_a;          // [R18]
                    r_next.trim_b = offset_result_b;
                    if (r_reg.state == st_fg_ofs)
                    begin
                        r_next.done  = 1'b1;
                        r_next.state = st_idle;
                    end
                    else
                    begin
                        r_next.state = st_sleep;
                    end
                end
            st_sleep:
                // Switching rule chosen by the low-power select [R13]
                if (!r_reg.ctrl[`ACS_B_BG_EN])
                begin
                    r_next.state = st_idle;
                end
                else if (!r_reg.ctrl[`ACS_B_LOW_POWER_SPARE_ENABLE])
                begin
                    r_next.bank  = {r_reg.spare, 1'b0};
                    r_next.state = st_bg_cal;
                end
                else if (r_reg.ctrl[`ACS_B_LP_SW_SEL] ? trig_edge
                         : (r_reg.cnt == 16'h0))              // [R11]
                begin
                    r_next.cnt   = r_reg.settle_dly;
                    r_next.state = st_wake;
                end
                else if (!r_reg.ctrl[`ACS_B_LP_SW_SEL])
                begin
                    r_next.cnt = r_reg.cnt - 16'h1;
                end
            st_wake:
                if (r_reg.cnt == 16'h0)                       // [R12]
                begin
                    r_next.bank  = {r_reg.spare, 1'b0};
                    r_next.state = st_bg_cal;
                end
                else
                begin
                    r_next.cnt = r_reg.cnt - 16'h1;
                end
            st_bg_cal:
                if (cal_step_done && !r_reg.bank[0])
                begin
                    r_next.bank = r_reg.bank + 3'h1;
                end
                else if (cal_step_done)
                begin
                    // Calibrated spare takes over one slot [R4] [R9]
                    r_next.target = !r_reg.target;
                    if (r_reg.target)
                    begin
                        r_next.slot_b = r_reg.spare;
                        r_next.spare  = r_reg.slot_b;
                    end
                    else
                    begin
                        r_next.slot_a = r_reg.spare;
                        r_next.spare  = r_reg.slot_a;
                    end
                    r_next.cnt   = r_reg.sleep_dly;
                    r_next.state = r_reg.ctrl[`ACS_B_BG_OFS_EN]
                                 ? st_bg_ofs : st_sleep;      // [R16]
                end
            default:
                r_next.state = st_idle;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r_reg            <= '0;
            r_reg.state      <= st_idle;
            r_reg.ctrl       <= `ACS_CTRL_RST;
            r_reg.sleep_dly  <= `ACS_SLEEP_RST;
            r_reg.settle_dly <= `ACS_SETTLE_RST;
            r_reg.pu_pend    <= 1'b1;
            r_reg.slot_b     <= 2'h1;
            r_reg.spare      <= 2'h2;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_last_bank;
        r_reg.state == st_fg_bnk && cal_step_done
            && r_reg.bank == 3'h5;
    endsequence
    sequence s_fg_start;
        r_reg.state == st_idle && r_next.state == st_fg_bnk;
    endsequence

    a_mute_mid_code: assert property ( // [R1]
        @(posedge ref_clk) disable iff (!rstn)
        fg_run |=> sample_out == 12'h000)
        else $error("sample not mid-code during calibration");
    a_cores_offline: assert property ( // [R1]
        @(posedge ref_clk) disable iff (!rstn)
        fg_run |-> core_online == 3'h0 && core_power_on == 3'h7)
        else $error("core online during foreground");
    a_trig_start: assert property ( // [R22]
        @(posedge ref_clk) disable iff (!rstn)
        r_reg.state == st_idle && trig_edge && !r_reg.pu_pend
            && r_reg.ctrl[0] && !r_reg.ctrl[2]
        |=> r_reg.state == st_fg_bnk && r_reg.bank == 3'h0)
        else $error("trigger did not start calibration");
    a_trig_ignored: assert property ( // [R22]
        @(posedge ref_clk) disable iff (!rstn)
        r_reg.state == st_fg_bnk && !cal_step_done
        |=> r_reg.state == st_fg_bnk && $stable(r_reg.bank))
        else $error("running calibration disturbed");
    a_done_clear: assert property ( // [R21]
        @(posedge ref_clk) disable iff (!rstn)
        s_fg_start |=> !r_reg.done ##1 !r_reg.done)
        else $error("done flag not cleared at start");
    a_done_after_banks: assert property ( // [R15]
        @(posedge ref_clk) disable iff (!rstn)
        s_last_bank |=> (r_reg.ctrl[5] ? (r_reg.state == st_fg_ofs
            && !r_reg.done) : (r_reg.state == st_idle && r_reg.done)))
        else $error("wrong step after last bank");
    a_bg_two_online: assert property ( // [R9]
        @(posedge ref_clk) disable iff (!rstn)
        bg_run |-> $countones(core_online) == 2
            && (core_online & onehot3(r_reg.spare)) == 3'h0)
        else $error("background slot count wrong");
    a_lp_sleep_off: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rstn)
        r_reg.state == st_sleep && r_reg.ctrl[3]
        |-> (core_power_on & onehot3(r_reg.spare)) == 3'h0)
        else $error("sleeping spare powered");
    a_settle_hold: assert property ( // [R12]
        @(posedge ref_clk) disable iff (!rstn)
        r_reg.state == st_wake && r_reg.cnt != 16'h0
        |=> r_reg.state == st_wake && r_reg.cnt == $past(r_reg.cnt) - 1)
        else $error("settle delay cut short");
    a_trim_locked: assert property ( // [R18]
        @(posedge ref_clk) disable iff (!rstn)
        r_reg.loaded && ofs_lock && !offset_step_done
            && avs_write && bus_take && avs_address == 4'h4
        |=> $stable(r_reg.trim_a) && $stable(r_reg.trim_b))
        else $error("trim written under offset calibration");
endmodule

// *** dv/test_adc_calibration_sequencer.sv ***
// Self-checking bench of the calibration sequencer
`timescale 1ns/1ns
`include "acs_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_adc_calibration_sequencer;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd, v;
    logic        wreq, creq, oreq;
    logic        pin = 1'b0;
    logic        cdone = 1'b0;
    logic        odone = 1'b0;
    logic [11:0] fa = 12'h0;
    logic [11:0] fb = 12'h0;
    logic [11:0] ra = 12'h0;
    logic [11:0] rb = 12'h0;
    logic [11:0] sin = 12'h0;
    logic [11:0] sin_d = 12'h0;
    logic [11:0] sout, ta, tb, e;
    logic [2:0]  bsel, onl_o, pwr, inb;
    logic [8:0]  cv [3] = '{9'h100, 9'h000, 9'h080};
    logic [1:0]  ce [3] = '{2'b11, 2'b00, 2'b10};
    int          n_fail = 0;
    int          checks = 0;
    int          spare, slot_a, slot_b, tgt, n_wait, sl, st, t, i, bgo;

    acs_sequencer acs_sequencer_i
    (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .calibration_trigger_pin(pin),
        .factory_offset_a(fa), .factory_offset_b(fb), .cal_step_req(creq),
        .cal_bank_sel(bsel), .cal_step_done(cdone), .offset_step_req(oreq),
        .offset_step_done(odone), .offset_result_a(ra), .offset_result_b(rb),
        .core_online(onl_o), .core_power_on(pwr), .core_input_b(inb),
        .sample_in(sin), .sample_out(sout)
    );

    // ----------------------------------------------------------
    // Clock, live samples and drivers
    // ----------------------------------------------------------
    always #50 ref_clk = ~ref_clk;

    // Delayed copy, since the output register lags the input a cycle
    always @(posedge ref_clk)
    begin
        sin <= 12'($urandom);
        sin_d <= sin;
    end

    task conclude;
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task give_up;
        n_fail++;
        conclude();
    endtask

    // Request held until waitrequest samples low at an edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        adr <= a;
        wr_en <= w;
        rd_en <= !w;
        wdat <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge ref_clk);
            if (wreq === 1'b0)
                break;
        end
        if (i == 20)
            give_up();
        rd = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task await(input logic ofs);
        for (i = 0; i < 400; i++)
        begin
            @(posedge ref_clk);
            if ((ofs ? oreq : creq) === 1'b1)
                break;
        end
        if (i == 400)
            give_up();
        n_wait = i + 1;
    endtask

    // Checked at the done edge: the first fg cycle may still carry data
    task bank(input int b, input int onl, input logic fg);
        await(1'b0);
        cdone <= 1'b1;
        @(posedge ref_clk);
        cdone <= 1'b0;
        e = fg ? 12'h000 : sin_d;
        `CHK(bsel, 3'(b))
        `CHK({sout, onl_o, pwr}, {e, 3'(onl), 3'h7})
        if (!fg)
            `CHK({inb[slot_a], inb[slot_b]}, 2'b01)
    endtask

    // Pin pulses mid-run; a restart would break the bank order
    task fg_run(input logic ofs);
        for (int b = 0; b < 6; b++)
        begin
            if (b > 1)
                pin <= (b == 2);
            bank(b, 0, 1'b1);
        end
        if (ofs)
            ofs_step();
    endtask

    // Offset step answered with fresh random results
    task ofs_step;
        await(1'b1);
        `CHK(creq, 1'b0)
        ra <= 12'($urandom);
        rb <= 12'($urandom);
        odone <= 1'b1;
        @(posedge ref_clk);
        odone <= 1'b0;
        ta = ra;
        tb = rb;
    endtask

    task bg_rot;
        t = (1 << slot_a) | (1 << slot_b);
        bank(2 * spare, t, 1'b0);
        bank(2 * spare + 1, t, 1'b0);
        t = tgt ? slot_b : slot_a;
        if (tgt)
            slot_b = spare;
        else
            slot_a = spare;
        spare = t;
        tgt ^= 1;
        if (bgo)
            ofs_step();
    endtask

    task rst_cycle;
        rstn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        `CHK({onl_o, pwr, sout}, {3'h3, 3'h3, 12'h000})
        rstn <= 1'b1;
        spare = 2;
        slot_a = 0;
        slot_b = 1;
        tgt = 0;
        ta = fa;
        tb = fb;
        fg_run(1'b0);
        bus(1'b0, `ACS_OFS_CTRL, 32'h0);
        `CHK(rd[8:0], `ACS_CTRL_RST)
        bus(1'b0, `ACS_OFS_DELAY, 32'h0);
        `CHK(rd, {`ACS_SETTLE_RST, `ACS_SLEEP_RST})
        bus(1'b0, `ACS_OFS_TRIM, 32'h0);
        `CHK(rd, {4'h0, tb, 4'h0, ta})
        bus(1'b0, `ACS_OFS_STATUS, 32'h0);
        `CHK({rd[17:13], rd[9:0]}, {5'h0e, 10'h009})
        bus(1'b0, 4'h9, 32'h0);
        `CHK(rd, 32'h0)
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial
    begin
        void'($urandom(81));
        fa <= 12'($urandom);
        fb <= 12'($urandom);
        rst_cycle();
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, `ACS_OFS_CTRL, {23'h0, cv[k]});
            bus(1'b0, `ACS_OFS_CTRL, 32'h0);
            `CHK(rd[8:0], cv[k])
            `CHK(inb[1:0], ce[k])
        end
        // Pin selected: nothing without enable, software bit ignored
        bus(1'b1, `ACS_OFS_CTRL, 32'h082);
        pin <= 1'b1;
        @(posedge ref_clk);
        pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK(creq, 1'b0)
        bus(1'b1, `ACS_OFS_CTRL, 32'h083);
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h1);
        repeat (4) @(posedge ref_clk);
        `CHK(creq, 1'b0)
        pin <= 1'b1;
        @(posedge ref_clk);
        pin <= 1'b0;
        fg_run(1'b0);
        // One-time offset step; trim writes refused while its enable is set
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h0);
        bus(1'b1, `ACS_OFS_CTRL, 32'h0a1);
        v = $urandom;
        bus(1'b1, `ACS_OFS_TRIM, v);
        bus(1'b0, `ACS_OFS_TRIM, 32'h0);
        `CHK(rd, {4'h0, tb, 4'h0, ta})
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h1);
        repeat (2) @(posedge ref_clk);
        bus(1'b0, `ACS_OFS_STATUS, 32'h0);
        `CHK(rd[1:0], 2'b10)
        fg_run(1'b1);
        bus(1'b0, `ACS_OFS_STATUS, 32'h0);
        `CHK(rd[1:0], 2'b01)
        bus(1'b0, `ACS_OFS_TRIM, 32'h0);
        `CHK(rd, {4'h0, tb, 4'h0, ta})
        `CHK(oreq, 1'b0)
        bus(1'b1, `ACS_OFS_CTRL, 32'h081);
        v = $urandom;
        bus(1'b1, `ACS_OFS_TRIM, v);
        bus(1'b0, `ACS_OFS_TRIM, 32'h0);
        `CHK(rd, {4'h0, v[27:16], 4'h0, v[11:0]})
        // Background rotation, then a reset in mid-run
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h0);
        bus(1'b1, `ACS_OFS_CTRL, 32'h0c5);
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h1);
        bgo = 1;
        repeat (3) bg_rot();
        bgo = 0;
        // Offset step off before the trims are read back
        bus(1'b1, `ACS_OFS_CTRL, 32'h085);
        bus(1'b0, `ACS_OFS_TRIM, 32'h0);
        `CHK(rd, {4'h0, tb, 4'h0, ta})
        rst_cycle();
        // Low-power rotation in dual channel with short delays
        sl = $urandom_range(4, 1);
        st = $urandom_range(4, 1);
        bus(1'b1, `ACS_OFS_DELAY, {16'(st), 16'(sl)});
        bus(1'b1, `ACS_OFS_CTRL, 32'h08d);
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h1);
        repeat (2)
        begin
            bg_rot();
            @(posedge ref_clk);
            `CHK(pwr, 3'((1 << slot_a) | (1 << slot_b)))
            await(1'b0);
            `CHK(n_wait, sl + st + 2)
        end
        // Trigger-driven switching: spare sleeps until a fresh edge
        bus(1'b1, `ACS_OFS_CTRL, 32'h09d);
        bg_rot();
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h0);
        repeat (8) @(posedge ref_clk);
        `CHK(creq, 1'b0)
        bus(1'b1, `ACS_OFS_SOFT_TRIG, 32'h1);
        await(1'b0);
        `CHK(n_wait, st + 3)
        conclude();
    end
endmodule
